// [logic/tdm_port_defines.svh]
`ifndef TDM_PORT_DEFINES_SVH
`define TDM_PORT_DEFINES_SVH
// Behaviour
// - interface type code 00 serial, 01 E1, 10 T1 picks each shared pin's function.
// - all port pins act only when external mode bit is 1.
// - E1 or T1 drives transmit signaling bits on the shared output.
// - serial drives shared output as clear-to-send at the software level.
// - two-clock mode samples data, sync and signaling with the receive clock.
// - one-clock mode ignores receive clock and uses transmit clock both ways.
// - clock arrangement bit 1 selects two-clock mode, 0 one-clock mode.
// - receive edge bit 1 latches on rising edge, 0 on falling edge.
// - high-speed mode takes receive clock and data only on port one.
// - two-clock aligns from receive sync; one-clock aligns from transmit sync.
// - E1 or T1 captures incoming signaling with the selected receive clock.
// - serial shows live request-to-send level in a read-only status bit.
// - receive data is sampled with the selected receive-side clock.
// - transmit edge bit 0 updates outputs rising, 1 falling; sync opposite edge.
// - global high-speed bit set to 1 selects high-speed operation.
`define IF_SERIAL 2'h0
`define IF_E1 2'h1
`define IF_T1 2'h2
`define TWO_CLOCKS 1'h1
`define RX_RISING 1'h1
`define TX_FALLING 1'h1
`define EXT_MODE 1'h1
`define HIGH_SPEED 1'h1
`define BUF_DEPTH 2
`endif

// [logic/tdm_port_pkg.sv]
package tdm_port_pkg;
  typedef struct packed {
    logic data;
    logic sync;
    logic sig;
  } rx_bit_s;
  typedef struct packed {
    logic [1:0] if_type;
    logic two_clocks;
    logic rx_rising;
    logic tx_falling;
    logic cts_level;
  } port_cfg_s;
endpackage

// [logic/tdm_port_receive_serial_interface.sv]
`timescale 1ns/1ps
`include "tdm_port_defines.svh"
module tdm_port_receive_serial_interface
  import tdm_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic external_mode_select,
  input wire logic high_speed_select,
  input wire logic port_is_one,
  input wire port_cfg_s cfg,
  // line pins
  input wire logic rx_line_clock_in,
  input wire logic tx_line_clock_in,
  input wire logic rx_serial_data_in,
  input wire logic rx_frame_sync_in,
  input wire logic rx_signaling_or_request_to_send_in,
  input wire logic tx_frame_sync_in,
  output logic tx_signaling_or_clear_to_send_out,
  // transmit signaling source
  input wire logic tx_sig_bit,
  // receive stream out
  output rx_bit_s rx_out,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  // status
  output logic port_status_one,
  output logic frame_aligned
);
  typedef struct packed {
    logic [1:0] rclk_s;
    logic [1:0] tclk_s;
    logic [1:0] data_s;
    logic [1:0] sync_s;
    logic [1:0] sig_s;
    logic [1:0] txs_s;
    logic rclk_p;
    logic tclk_p;
    rx_bit_s [`BUF_DEPTH-1:0] buf_q;
    logic [1:0] cnt;
    logic wp;
    logic rp;
    logic out;
    logic rts;
    logic aligned;
    logic active_p;
  } state_s;

  state_s s_q;
  state_s s_d;

  // --------------------------------------------------
  // derived selections
  // --------------------------------------------------
  logic active;
  logic is_serial;
  logic two_clk;
  logic rx_clk_lvl;
  logic rx_clk_prev;
  logic rx_edge;
  logic tx_edge;
  logic tx_in_edge;
  logic buf_push;
  logic buf_pop;
  logic sync_now;
  rx_bit_s sample;

  function automatic logic edge_of(input logic cur, input logic prev, input logic rising);
    edge_of = rising ? (cur && !prev) : (!cur && prev);
  endfunction

  always_comb begin
    // pins live only in external mode; high speed uses port one alone
    active = (external_mode_select == `EXT_MODE) &&
             !((high_speed_select == `HIGH_SPEED) && !port_is_one);
    is_serial = (cfg.if_type == `IF_SERIAL);
    two_clk = (cfg.two_clocks == `TWO_CLOCKS);
    rx_clk_lvl = two_clk ? s_q.rclk_s[1] : s_q.tclk_s[1];
    rx_clk_prev = two_clk ? s_q.rclk_p : s_q.tclk_p;
    rx_edge = active && edge_of(rx_clk_lvl, rx_clk_prev, cfg.rx_rising == `RX_RISING);
    tx_edge = active &&
              edge_of(s_q.tclk_s[1], s_q.tclk_p, cfg.tx_falling != `TX_FALLING);
    tx_in_edge = active && edge_of(s_q.tclk_s[1], s_q.tclk_p, cfg.tx_falling == `TX_FALLING);
    // sync and signaling taken with the data sample
    sync_now = two_clk ? s_q.sync_s[1] : s_q.txs_s[1];
    sample.data = s_q.data_s[1];
    sample.sync = sync_now;
    sample.sig = is_serial ? 1'h0 : s_q.sig_s[1];
    buf_push = rx_edge && (s_q.cnt != 2'(`BUF_DEPTH));
    buf_pop = rx_out_valid && rx_out_ready;
  end

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rclk_s = {s_q.rclk_s[0], rx_line_clock_in};
    s_d.tclk_s = {s_q.tclk_s[0], tx_line_clock_in};
    s_d.data_s = {s_q.data_s[0], rx_serial_data_in};
    s_d.sync_s = {s_q.sync_s[0], rx_frame_sync_in};
    s_d.sig_s = {s_q.sig_s[0], rx_signaling_or_request_to_send_in};
    s_d.txs_s = {s_q.txs_s[0], tx_frame_sync_in};
    s_d.rclk_p = s_q.rclk_s[1];
    s_d.tclk_p = s_q.tclk_s[1];
    s_d.active_p = active;
    if (buf_push) begin
      s_d.buf_q[s_q.wp] = sample;
      s_d.wp = ~s_q.wp;
    end
    if (buf_pop) begin
      s_d.rp = ~s_q.rp;
    end
    s_d.cnt = s_q.cnt + 2'(buf_push) - 2'(buf_pop);
    // alignment: two-clock from rx sync on rx edge, one-clock from tx sync
    if (!active) begin
      s_d.aligned = 1'h0;
    end else if (two_clk && rx_edge && s_q.sync_s[1]) begin
      s_d.aligned = 1'h1;
    end else if (!two_clk && tx_in_edge && s_q.txs_s[1]) begin
      s_d.aligned = 1'h1;
    end
    // shared output updated on the selected transmit edge
    if (!active) begin
      s_d.out = 1'h0;
    end else if (tx_edge) begin
      s_d.out = is_serial ? cfg.cts_level : tx_sig_bit;
    end
    s_d.rts = active && is_serial && s_q.sig_s[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign rx_out = s_q.buf_q[s_q.rp];
  assign rx_out_valid = (s_q.cnt != 2'h0);
  assign tx_signaling_or_clear_to_send_out = s_q.out;
  assign port_status_one = s_q.rts;
  assign frame_aligned = s_q.aligned;

  // --------------------------------------------------
  // checks: shared output
  // --------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence serial_cts_edge;
    tx_edge && is_serial;
  endsequence

  sequence tclk_rise;
    !s_q.tclk_s[1] ##1 s_q.tclk_s[1];
  endsequence

  sequence tclk_fall;
    s_q.tclk_s[1] ##1 !s_q.tclk_s[1];
  endsequence

  a_cts_level: assert property (
    serial_cts_edge |=> s_q.out == $past(cfg.cts_level))
    else $error("cts level not driven");

  a_sig_out: assert property (
    tx_edge && !is_serial |=> s_q.out == $past(tx_sig_bit))
    else $error("signaling bit not driven");

  a_out_hold: assert property (
    active && !tx_edge |=> $stable(s_q.out))
    else $error("shared output moved off its edge");

  a_tx_rise_edge: assert property (
    tclk_rise ##0 (active && cfg.tx_falling != `TX_FALLING) |-> tx_edge)
    else $error("rising transmit edge missed");

  a_tx_fall_edge: assert property (
    tclk_fall ##0 (active && cfg.tx_falling == `TX_FALLING) |-> tx_edge)
    else $error("falling transmit edge missed");

  a_inactive_low: assert property (
    !active |=> !tx_signaling_or_clear_to_send_out && !s_q.aligned)
    else $error("pins active outside external mode");

  a_leave_clears: assert property (
    s_q.active_p && !active |=> !frame_aligned)
    else $error("alignment kept after leaving external mode");

  a_hs_port: assert property (
    high_speed_select && !port_is_one |-> !rx_edge && !tx_edge)
    else $error("non-port-one active in high speed");

  a_hs_out_low: assert property (
    high_speed_select && !port_is_one |=> !tx_signaling_or_clear_to_send_out)
    else $error("non-port-one output driven in high speed");

  // --------------------------------------------------
  // checks: receive side
  // --------------------------------------------------

  sequence rclk_rise;
    !s_q.rclk_s[1] ##1 s_q.rclk_s[1];
  endsequence

  sequence rclk_fall;
    s_q.rclk_s[1] ##1 !s_q.rclk_s[1];
  endsequence

  a_two_clk_rise: assert property (
    rclk_rise ##0 (active && two_clk && cfg.rx_rising && s_q.cnt != 2'h2) |-> buf_push)
    else $error("rising receive edge not sampled");

  a_two_clk_fall: assert property (
    rclk_fall ##0 (active && two_clk && !cfg.rx_rising && s_q.cnt != 2'h2) |-> buf_push)
    else $error("falling receive edge not sampled");

  a_one_clk_rise: assert property (
    tclk_rise ##0 (active && !two_clk && cfg.rx_rising && s_q.cnt != 2'h2) |-> buf_push)
    else $error("one-clock rising edge not sampled");

  a_one_clk_fall: assert property (
    tclk_fall ##0 (active && !two_clk && !cfg.rx_rising && s_q.cnt != 2'h2) |-> buf_push)
    else $error("one-clock falling edge not sampled");

  a_rclk_ignored: assert property (
    !two_clk && s_q.tclk_s[1] == s_q.tclk_p |-> !rx_edge)
    else $error("receive clock used in one-clock mode");

  a_tclk_ignored: assert property (
    two_clk && s_q.rclk_s[1] == s_q.rclk_p |-> !rx_edge)
    else $error("transmit clock used in two-clock mode");

  a_rx_no_edge: assert property (
    !rx_edge |=> s_q.wp == $past(s_q.wp))
    else $error("buffer written without receive edge");

  a_ext_off_quiet: assert property (
    !external_mode_select |-> !buf_push)
    else $error("capture outside external mode");

  a_rx_data_cap: assert property (
    buf_push |=> s_q.buf_q[$past(s_q.wp)].data == $past(s_q.data_s[1]))
    else $error("data sample lost");

  a_one_clk_sync: assert property (
    buf_push && !two_clk |=> s_q.buf_q[$past(s_q.wp)].sync == $past(s_q.txs_s[1]))
    else $error("one-clock sync not from tx sync");

  a_two_clk_sync: assert property (
    buf_push && two_clk |=> s_q.buf_q[$past(s_q.wp)].sync == $past(s_q.sync_s[1]))
    else $error("two-clock sync not with data");

  a_sig_capture: assert property (
    buf_push && !is_serial |=> s_q.buf_q[$past(s_q.wp)].sig == $past(s_q.sig_s[1]))
    else $error("signaling bit not captured");

  a_serial_sig_zero: assert property (
    buf_push && is_serial |=> !s_q.buf_q[$past(s_q.wp)].sig)
    else $error("signaling captured in serial mode");

  a_align_two: assert property (
    two_clk && rx_edge && s_q.sync_s[1] |=> frame_aligned)
    else $error("receive sync did not align");

  a_align_one: assert property (
    !two_clk && tx_in_edge && s_q.txs_s[1] |=> frame_aligned)
    else $error("transmit sync did not align");

  a_rts_status: assert property (
    active && is_serial |=> port_status_one == $past(s_q.sig_s[1]))
    else $error("rts status wrong");

  a_rts_zero: assert property (
    !is_serial |=> !port_status_one)
    else $error("rts status outside serial mode");

  // --------------------------------------------------
  // checks: buffer
  // --------------------------------------------------

  a_buf_full: assert property (
    s_q.cnt == 2'h2 && !buf_pop |=> s_q.cnt == 2'h2)
    else $error("buffer overflow");

  a_cnt_bound: assert property (
    s_q.cnt != 2'h3)
    else $error("buffer count out of range");

  a_no_push_full: assert property (
    s_q.cnt == 2'h2 |-> !buf_push)
    else $error("push into full buffer");

  a_push_advance: assert property (
    buf_push |=> s_q.wp != $past(s_q.wp))
    else $error("write pointer stuck");

  a_pop_advance: assert property (
    buf_pop |=> s_q.rp != $past(s_q.rp))
    else $error("read pointer stuck");

  a_second_word: assert property (
    s_q.cnt == 2'h1 && buf_push && !buf_pop |=> s_q.cnt == 2'h2 && rx_out_valid)
    else $error("second word not held");
endmodule

// [test/far_end_framer.sv]
`timescale 1ns/1ps
module far_end_framer #(
  parameter logic [7:0] PAT = 8'hb4
) (
  // control
  input wire logic run,
  input wire logic rise,
  input wire logic rts,
  // line
  output logic lclk,
  output logic data,
  output logic sync,
  output logic sig
);
  logic [2:0] idx;
  initial begin
    lclk = 1'h0;
    idx = 3'h0;
    data = 1'h0;
    sync = 1'h0;
  end
  // clock runs only while run is high and stands still between scenarios
  always #100 if (run) lclk = ~lclk;
  // launch on the edge opposite the sampling edge
  always @(lclk) if (lclk != rise) begin
    idx = idx + 3'h1;
    data = PAT[idx];
    sync = (idx == 3'h0);
  end
  assign sig = run ? ~data : rts;
endmodule

// [test/tb_tdm_port_receive_serial_interface.sv]
`timescale 1ns/1ps
module tb_tdm_port_receive_serial_interface;
  import tdm_port_pkg::*;
  logic clk, rst, ext, hs, p1, ready, tsig, run, rts, slow;
  logic lclk, dat, syn, sig, cts, vld, stat, alig;
  port_cfg_s cfg;
  rx_bit_s w;
  int fail_count, comparisons, cyc;
  localparam logic [7:0] PAT = 8'hb4;
  far_end_framer #(.PAT(PAT)) u_far (.run(run), .rise(cfg.rx_rising), .rts(rts), .lclk(lclk),
    .data(dat), .sync(syn), .sig(sig));
  tdm_port_receive_serial_interface u_dut (.clk(clk), .rst(rst), .external_mode_select(ext),
    .high_speed_select(hs), .port_is_one(p1), .cfg(cfg),
    .rx_line_clock_in(cfg.two_clocks ? lclk : slow),
    .tx_line_clock_in(cfg.two_clocks ? slow : lclk),
    .rx_serial_data_in(dat), .rx_frame_sync_in(syn), .rx_signaling_or_request_to_send_in(sig),
    .tx_frame_sync_in(syn), .tx_signaling_or_clear_to_send_out(cts), .tx_sig_bit(tsig),
    .rx_out(w), .rx_out_valid(vld), .rx_out_ready(ready), .port_status_one(stat),
    .frame_aligned(alig));
  // ----------------------------
  // helpers
  // ----------------------------
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    slow = 1'h0;
    forever #300 slow = ~slow;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task stop_test();
    $display("errors %0d checks %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task get(output rx_bit_s x);
    int n;
    n = 0;
    while (vld !== 1'h1 && n < 200) begin
      tick(1);
      n++;
    end
    x = w;
    tick(1);
  endtask
  // ----------------------------
  // scenarios
  // ----------------------------
  task rx_run(input logic two, input logic rise, input logic [1:0] ift);
    rx_bit_s x;
    int n;
    cfg = '{ift, two, rise, 1'h0, 1'h0};
    run = 1'h1;
    n = 0;
    do begin
      get(x);
      n++;
    end while (x.sync !== 1'h1 && n < 24);
    for (int i = 0; i < 16; i++) begin
      if (i > 0) get(x);
      chk(x, {PAT[i%8], i % 8 == 0, ift != 2'h0 && !PAT[i%8]});
    end
    chk(alig, 1'h1);
    run = 1'h0;
  endtask
  task pins();
    for (int k = 0; k < 4; k++) begin
      cfg = '{k > 1 ? 2'h1 : 2'h0, 1'h1, 1'h1, 1'h0, k == 0 || k == 3};
      rts = ~k[0];
      tsig = k[0] ^ k[1];
      tick(60);
      chk({cts, stat}, {k > 1 ? tsig : cfg.cts_level, k < 2 && rts});
    end
  endtask
  task gate(input logic e, input logic h, input logic p, input logic exp);
    int seen;
    seen = 0;
    tick(30);
    {ext, hs, p1} = {e, h, p};
    cfg = '{2'h0, 1'h1, 1'h1, 1'h0, 1'h1};
    run = 1'h1;
    repeat (80) begin
      tick(1);
      seen += (vld === 1'h1);
    end
    run = 1'h0;
    chk({seen != 0, cts}, {exp, exp});
  endtask
  task stall();
    int n;
    n = 0;
    tick(30);
    ready = 1'h0;
    run = 1'h1;
    tick(48);
    run = 1'h0;
    tick(12);
    ready = 1'h1;
    repeat (4) begin
      n += (vld === 1'h1);
      tick(1);
    end
    chk(n, 3'h2);
  endtask
  initial begin
    {rst, ext, hs, p1, ready, tsig, run, rts} = 8'hd9;
    cfg = '0;
    tick(6);
    rst = 1'h0;
    for (int m = 0; m < 4; m++) rx_run(m[0], m[1], 2'h1);
    rx_run(1'h1, 1'h1, 2'h2);
    rx_run(1'h1, 1'h0, 2'h0);
    pins();
    stall();
    gate(1'h0, 1'h0, 1'h1, 1'h0);
    gate(1'h1, 1'h1, 1'h0, 1'h0);
    gate(1'h1, 1'h1, 1'h1, 1'h1);
    stop_test();
  end
endmodule
